// ==== shared/adc_readout_params.svh ====
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 8500
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define RESULT_BITS 12
`define FRAME_BITS 13
`define BIT_CNT_W 4
`define CONV_CNT_W 10
`endif

// ==== shared/adc_readout_pkg.sv ====
package adc_readout_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_SHIFT = 2'b10
    } conv_state_e;

    typedef struct packed {
        logic data_o;
        logic data_oe;
    } dout_pin_s;

    typedef struct packed {
        logic [11:0] result;
    } sample_word_s;
endpackage : adc_readout_pkg

// ==== design/serial_adc_readout.sv ====
`timescale 1ns/100ps
`include "adc_readout_params.svh"
module serial_adc_readout (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [11:0] sample_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic busy_o
);
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] cs_sync_r;
    logic [1:0] sclk_sync_r;
    logic cs_d_r;
    logic sclk_d_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cs_sync_r <= 2'h3;
            sclk_sync_r <= 2'h0;
            cs_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], cs_n_i};
            sclk_sync_r <= {sclk_sync_r[0], sclk_i};
            cs_d_r <= cs_sync_r[1];
            sclk_d_r <= sclk_sync_r[1];
        end
    end

    wire cs_low = ~cs_sync_r[1];
    wire cs_fall = cs_d_r & ~cs_sync_r[1];
    wire sclk_fall = sclk_d_r & ~sclk_sync_r[1];

    // ****************************************
    // conversion control
    // ****************************************
    adc_readout_pkg::conv_state_e state_r;
    adc_readout_pkg::conv_state_e state_nxt;
    logic [`CONV_CNT_W-1:0] conv_cnt_r;
    logic [`FRAME_BITS-1:0] shift_r;
    adc_readout_pkg::dout_pin_s pin;

    wire conv_done = (conv_cnt_r == `CONV_CNT_W'(`CONV_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adc_readout_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    state_nxt = adc_readout_pkg::ST_CONV;
                end
            end
            adc_readout_pkg::ST_CONV: begin
                if (!cs_low) begin
                    state_nxt = adc_readout_pkg::ST_IDLE;
                end else if (conv_done) begin
                    state_nxt = adc_readout_pkg::ST_SHIFT;
                end
            end
            adc_readout_pkg::ST_SHIFT: begin
                if (!cs_low) begin
                    state_nxt = adc_readout_pkg::ST_IDLE;
                end
            end
            default: state_nxt = adc_readout_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= adc_readout_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // the counter only runs during conversion; sclk is ignored meanwhile
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            conv_cnt_r <= '0;
        end else if (state_r == adc_readout_pkg::ST_CONV) begin
            conv_cnt_r <= conv_cnt_r + `CONV_CNT_W'(1);
        end else begin
            conv_cnt_r <= '0;
        end
    end

    // leading 1 sits at the top; zeros fill from below after the LSB
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            shift_r <= '0;
        end else if (state_r == adc_readout_pkg::ST_CONV && conv_done && cs_low) begin
            shift_r <= {1'b1, sample_i};
        end else if (state_r == adc_readout_pkg::ST_SHIFT && sclk_fall) begin
            shift_r <= {shift_r[`FRAME_BITS-2:0], 1'b0};
        end
    end

    // ****************************************
    // result pin
    // ****************************************
    assign pin.data_oe = cs_low && (state_r != adc_readout_pkg::ST_IDLE || cs_fall);
    assign pin.data_o = (state_r == adc_readout_pkg::ST_SHIFT) ? shift_r[`FRAME_BITS-1] : 1'b0;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dout_o <= 1'b0;
            dout_oe_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            dout_o <= pin.data_o;
            dout_oe_o <= pin.data_oe;
            busy_o <= (state_nxt == adc_readout_pkg::ST_CONV);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_start;
        state_r == adc_readout_pkg::ST_IDLE && cs_fall;
    endsequence

    property p_start_low;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_start |=> dout_oe_o && !dout_o && busy_o;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no low drive at start");

    property p_hiz_when_deselected;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(cs_sync_r[1]) && cs_sync_r[1] && !cs_fall |=> !dout_oe_o;
    endproperty
    a_hiz_when_deselected: assert property (p_hiz_when_deselected)
        else $error("result line driven while deselected");

    property p_abort;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_CONV && !cs_low |=> state_r == adc_readout_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not abandoned");

    property p_eoc_high;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_CONV && conv_done && cs_low |=> ##1 dout_o;
    endproperty
    a_eoc_high: assert property (p_eoc_high) else $error("end of conversion not high");

    property p_shift_on_fall;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_SHIFT && sclk_fall && cs_low
        |=> shift_r[`FRAME_BITS-1] == $past(shift_r[`FRAME_BITS-2]);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("bad shift on fall");

    property p_hold_no_fall;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_SHIFT && !sclk_fall |=> $stable(shift_r);
    endproperty
    a_hold_no_fall: assert property (p_hold_no_fall) else $error("shift without fall");

    property p_zero_fill;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_SHIFT && sclk_fall |=> shift_r[0] == 1'b0;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("trailing bit not zero");

    // busy length counted apart from the conversion counter, so a wrong terminal count shows
    logic [`CONV_CNT_W-1:0] busy_len_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            busy_len_r <= '0;
        end else if (busy_o) begin
            busy_len_r <= busy_len_r + `CONV_CNT_W'(1);
        end else begin
            busy_len_r <= '0;
        end
    end

    property p_conv_len;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) && dout_oe_o |-> busy_len_r == `CONV_CNT_W'(`CONV_CYCLES);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_busy_drives_low;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        busy_o |-> dout_oe_o && !dout_o;
    endproperty
    a_busy_drives_low: assert property (p_busy_drives_low) else $error("busy without low");

    property p_dout_tracks;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == adc_readout_pkg::ST_SHIFT |=> dout_o == $past(shift_r[`FRAME_BITS-1]);
    endproperty
    a_dout_tracks: assert property (p_dout_tracks) else $error("result line off shifter");

endmodule : serial_adc_readout

// ==== tb/adc_host_model.sv ====
`timescale 1ns/100ps
// ********
// host serial master
// ********
module adc_host_model (
    input wire logic ref_clk_i,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    output logic cs_n_o,
    output logic sclk_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wait_clk
    task automatic select(input logic lvl, input int hold_n);
        cs_n_o = lvl;
        wait_clk(hold_n);
    endtask : select
    // a released line reads as the inverse, so a late or missing drive is caught
    wire line_w = dout_oe_i ? dout_i : ~dout_i;
    // phases of 20 cycles: 2.5 MHz, twice the 100 ns floor on each clock phase
    task automatic frame(input int n_clk, output logic [15:0] bits, output logic low_seen,
                         output logic eoc_seen);
        int k;
        select(1'b0, 6);
        low_seen = dout_oe_i && !dout_i;
        eoc_seen = 1'b0;
        for (k = 0; k < 1000 && !eoc_seen; k++) begin
            wait_clk(1);
            eoc_seen = dout_oe_i && dout_i;
        end
        bits = '0;
        for (k = 0; k < n_clk; k++) begin
            wait_clk(20);
            sclk_o = 1'b1;
            bits = {bits[14:0], line_w};
            wait_clk(20);
            sclk_o = 1'b0;
        end
        wait_clk(10);
        select(1'b1, 20);
    endtask : frame
endmodule : adc_host_model

// ==== tb/serial_adc_readout_tb.sv ====
`timescale 1ns/100ps
`define CHECK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module serial_adc_readout_tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] sample_i = 12'h000;
    logic cs_n, sclk, dout, dout_oe, busy;
    logic [15:0] bits;
    logic low_seen, eoc_seen;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    serial_adc_readout DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .sample_i(sample_i), .dout_o(dout), .dout_oe_o(dout_oe), .busy_o(busy));
    adc_host_model host (.ref_clk_i(ref_clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
        .cs_n_o(cs_n), .sclk_o(sclk));
    task automatic results;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // ********
    // scenarios
    // ********
    task automatic run_frame(input logic [11:0] val, input int n_clk, input logic [15:0] exp);
        sample_i = val;
        host.frame(n_clk, bits, low_seen, eoc_seen);
        `CHECK(low_seen, 1'b1)
        `CHECK(eoc_seen, 1'b1)
        `CHECK(bits, exp)
        `CHECK(dout_oe, 1'b0)
    endtask : run_frame
    task automatic test_byte_mode;
        run_frame(12'hA5C, 16, {1'b1, 12'hA5C, 3'b000});
        run_frame(12'h0F3, 16, {1'b1, 12'h0F3, 3'b000});
    endtask : test_byte_mode
    task automatic test_exact13;
        run_frame(12'hFFF, 13, {3'b000, 1'b1, 12'hFFF});
        run_frame(12'h001, 13, {3'b000, 1'b1, 12'h001});
    endtask : test_exact13
    task automatic test_abort;
        sample_i = 12'h5A5;
        host.select(1'b0, 100);
        `CHECK(busy, 1'b1)
        `CHECK(dout, 1'b0)
        host.select(1'b1, 100);
        `CHECK(busy, 1'b0)
        `CHECK(dout_oe, 1'b0)
        run_frame(12'h3C6, 16, {1'b1, 12'h3C6, 3'b000});
    endtask : test_abort
    initial begin
        repeat (6) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        host.wait_clk(4);
        `CHECK(dout_oe, 1'b0)
        test_byte_mode();
        test_exact13();
        test_abort();
        results();
    end
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : serial_adc_readout_tb
